/* include/dsr_pkg.sv */
// Purpose: constants and carriers for the drive status readback block
// Assumes: 40 MHz system clock, 20-bit serial words, MSB first
// Notes: coil index 0 is coil A, index 1 is coil B
// Operation
// RULE_01: return one 20-bit status word for every configuration word written.
// RULE_02: response shifts MSB first in the same frame, latched at frame start.
// RULE_03: readback select sits at bits 5 and 4 of the driver config word.
// RULE_04: select setting in force at response build picks the upper field format.
// RULE_05: controller ignores reserved response bits.
// RULE_06: code 0 puts the 10-bit coil A sine table position in bits 19..10.
// RULE_07: position format bit 19 is coil A current polarity.
// RULE_08: code 1 full load value; code 2 load top five plus current scale.
// RULE_09: code 3 gives supply, enable, four short flags, four temperature detectors.
// RULE_10: bits 9..8 read 1 only for code 3 on newer revision.
// RULE_11: bit 7 set when no step edge within the last 2^20 clocks.
// RULE_12: open load flags set when a constant polarity interval had no chopper event.
// RULE_13: open load flag clears only when coil current exceeds one sixteenth maximum.
// RULE_14: controller treats open load as informational, checked only in slow motion.
// RULE_15: short flags report shorts; each short counts up and suspends chopper cycle.
// RULE_16: short counter counts down on each polarity change of its coil.
// RULE_17: counter reaching 3 switches the bridge off until shutdown cleared.
// RULE_18: shutdown clears only by disable input or zero chopper off time.
// RULE_19: bit 2 follows the overtemperature warning.
// RULE_20: bit 1 set when overtemperature shutdown occurred.
// RULE_21: bit 0 set at stall threshold, and stall test output driven high.
// RULE_22: example bring-up writes five configuration words in order; the bench writes six, two of them chopper config words.
// RULE_23: one example word enables adaptive current at quarter minimum.
`default_nettype none
package dsr_pkg;
  localparam int           RESP_W      = 20;
  localparam int           CNT_W       = 5;
  localparam logic [2:0]   ADDR_CONF   = 3'h7;
  localparam logic [2:0]   ADDR_CHOP   = 3'h4;
  localparam int           ADDR_LSB    = 17;
  localparam int           READBACK_SELECT_LSB   = 4;
  localparam int           CHOPPER_OFF_TIME_LSB    = 0;
  localparam int           CHOPPER_OFF_TIME_W      = 4;
  localparam logic [1:0]   READBACK_SELECT_RST   = 2'h0;
  localparam logic [3:0]   CHOPPER_OFF_TIME_RST    = 4'h0;
  localparam logic [1:0]   RD_POS      = 2'h0;
  localparam logic [1:0]   RD_LOAD     = 2'h1;
  localparam logic [1:0]   RD_LOAD_SC  = 2'h2;
  localparam logic [1:0]   RD_DIAG     = 2'h3;
  localparam logic [1:0]   SHORT_LIMIT = 2'h3;
  localparam int           STILL_CYC   = 1 << 20;
  localparam int           NUM_PINS    = 5;
  localparam int           PIN_SCLK    = 0;
  localparam int           PIN_CSN     = 1;
  localparam int           PIN_SDI     = 2;
  localparam int           PIN_STEP    = 3;
  localparam int           PIN_DIS     = 4;

  typedef struct packed {
    logic [9:0] sine_table_position;
    logic [9:0] load_measure_value;
    logic [4:0] adaptive_current_scale;
    logic       supply_below_7v_flag;
    logic [1:0] short_to_supply;
    logic [1:0] short_to_ground;
    logic [3:0] temp_detector;
    logic       overtemp_warning_flag;
    logic       overtemp_shutdown_flag;
    logic       stall_reached;
  } dsr_diag_s;

  typedef struct packed {
    logic chopper_event;
    logic current_above_16th;
    logic polarity;
  } dsr_coil_s;
endpackage
`default_nettype wire

/* hdl/dsr_link_shifter.sv */
// Purpose: 20-bit full-duplex serial shifter on sampled link edges
// Assumes: edges and levels already synchronised to mclk_i
// Notes: output changes on falling link clock, input taken on rising
`default_nettype none
module dsr_link_shifter
  import dsr_pkg::*;
(
  input  wire logic              mclk_i,
  input  wire logic              rstn_i,
  input  wire logic              frame_start_i,
  input  wire logic              frame_end_i,
  input  wire logic              sclk_rise_i,
  input  wire logic              sclk_fall_i,
  input  wire logic              sdi_i,
  input  wire logic [RESP_W-1:0] load_i,
  output logic                   sdo_o,
  output logic [RESP_W-1:0]      rx_word_o,
  output logic                   rx_done_o
);
  logic [RESP_W-1:0] tx_ff;
  logic [RESP_W-1:0] rx_ff;
  logic [CNT_W-1:0]  cnt_ff;
  logic              done_ff;

  // RULE_02 response loaded at frame start, MSB first
  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
      tx_ff <= '0;
    else if (frame_start_i)
      tx_ff <= load_i;
    else if (sclk_fall_i && cnt_ff != '0)
      tx_ff <= {tx_ff[RESP_W-2:0], 1'b0};
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      rx_ff  <= '0;
      cnt_ff <= '0;
    end
    else if (frame_start_i)
      cnt_ff <= '0;
    else if (sclk_rise_i)
    begin
      rx_ff <= {rx_ff[RESP_W-2:0], sdi_i};
      // saturate so overlong frames stay rejected
      if (cnt_ff != CNT_W'(31))
        cnt_ff <= cnt_ff + CNT_W'(1);
    end
  end

  // RULE_01 only exact 20-bit frames count as writes
  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
      done_ff <= 1'b0;
    else
      done_ff <= frame_end_i && (cnt_ff == CNT_W'(RESP_W));
  end

  assign sdo_o     = tx_ff[RESP_W-1];
  assign rx_word_o = rx_ff;
  assign rx_done_o = done_ff;
endmodule // dsr_link_shifter
`default_nettype wire

/* hdl/dsr_readback.sv */
// Purpose: drive status readback, short protection and link slave
// Assumes: link pins and step/disable pins are asynchronous to mclk_i
// Notes: analogue detector inputs are taken as mclk_i synchronous levels
`default_nettype none
module dsr_readback
  import dsr_pkg::*;
#(
  parameter int         STANDSTILL_CYCLES = STILL_CYC,
  parameter logic       NEWER_REV         = 1'b1
)
(
  input  wire logic            mclk_i,
  input  wire logic            rstn_i,
  input  wire logic            sclk_i,
  input  wire logic            csn_i,
  input  wire logic            sdi_i,
  output logic                 sdo_o,
  output logic                 sdo_oen_o,
  input  wire logic            step_i,
  input  wire logic            driver_disable_input_i,
  input  wire dsr_diag_s       diag_i,
  input  wire dsr_coil_s [1:0] coil_i,
  output logic [1:0]           readback_select_o,
  output logic [CHOPPER_OFF_TIME_W-1:0]    chopper_off_time_o,
  output logic                 bridge_off_o,
  output logic [1:0]           chopper_suspend_o,
  output logic                 stall_test_output_o
);
  // step clear check needs at least three idle cycles
  if (STANDSTILL_CYCLES < 3 || STANDSTILL_CYCLES > (1 << 24))
  begin : g_bad_still
    $error("STANDSTILL_CYCLES out of range");
  end

  logic [NUM_PINS-1:0] meta_ff;
  logic [NUM_PINS-1:0] sync_ff;
  logic [NUM_PINS-1:0] prev_ff;
  wire  [NUM_PINS-1:0] pins_in = {driver_disable_input_i, step_i, sdi_i, csn_i, sclk_i};

  // two-stage synchronisers; stage two and the edge-detect stage after it feed logic
  genvar gp;
  generate
    for (gp = 0; gp < NUM_PINS; gp++)
    begin : g_sync
      always_ff @(posedge mclk_i)
      begin
        if (!rstn_i)
        begin
          meta_ff[gp] <= (gp == PIN_CSN);
          sync_ff[gp] <= (gp == PIN_CSN);
          prev_ff[gp] <= (gp == PIN_CSN);
        end
        else
        begin
          meta_ff[gp] <= pins_in[gp];
          sync_ff[gp] <= meta_ff[gp];
          prev_ff[gp] <= sync_ff[gp];
        end
      end
    end
  endgenerate

  logic frame_start;
  logic frame_end;
  logic sclk_rise;
  logic sclk_fall;
  logic step_edge;
  logic driver_off;
  assign frame_start = prev_ff[PIN_CSN] && !sync_ff[PIN_CSN];
  assign frame_end   = !prev_ff[PIN_CSN] && sync_ff[PIN_CSN];
  assign sclk_rise   = !sync_ff[PIN_CSN] && sync_ff[PIN_SCLK] && !prev_ff[PIN_SCLK];
  assign sclk_fall   = !sync_ff[PIN_CSN] && !sync_ff[PIN_SCLK] && prev_ff[PIN_SCLK];
  assign step_edge   = sync_ff[PIN_STEP] && !prev_ff[PIN_STEP];
  assign driver_off  = sync_ff[PIN_DIS];

  // configuration words
  logic [RESP_W-1:0] rx_word;
  logic              rx_done;
  logic [1:0]        readback_select_ff;
  logic [CHOPPER_OFF_TIME_W-1:0] chopper_off_time_ff;
  logic [2:0]        rx_addr;
  assign rx_addr = rx_word[ADDR_LSB+:3];

  // RULE_03 select captured from the driver config word
  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
      readback_select_ff <= READBACK_SELECT_RST;
    else if (rx_done && rx_addr == ADDR_CONF)
      readback_select_ff <= rx_word[READBACK_SELECT_LSB+:2];
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
      chopper_off_time_ff <= CHOPPER_OFF_TIME_RST;
    else if (rx_done && rx_addr == ADDR_CHOP)
      chopper_off_time_ff <= rx_word[CHOPPER_OFF_TIME_LSB+:CHOPPER_OFF_TIME_W];
  end

  // RULE_11 standstill timer restarts on every active step edge
  logic [24:0] still_cnt_ff;
  logic        standstill_ff;
  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      still_cnt_ff  <= '0;
      standstill_ff <= 1'b0;
    end
    else if (step_edge)
    begin
      still_cnt_ff  <= '0;
      standstill_ff <= 1'b0;
    end
    else if (still_cnt_ff == 25'(STANDSTILL_CYCLES - 1))
      standstill_ff <= 1'b1;
    else
      still_cnt_ff <= still_cnt_ff + 25'h1;
  end

  // per-coil open load and short protection
  logic [1:0] ol_ff;
  logic [1:0] chop_seen_ff;
  logic [1:0] pol_prev_ff;
  logic [1:0] short_prev_ff;
  logic [1:0] shut_ff;
  logic [1:0] short_evt;
  logic [1:0] pol_chg;
  logic [1:0] cnt_ff [2];
  logic       shut_clear;
  // RULE_18 disable pin or zero off time releases shutdown
  assign shut_clear = driver_off || (chopper_off_time_ff == '0);

  genvar gc;
  generate
    for (gc = 0; gc < 2; gc++)
    begin : g_coil
      logic short_lvl;
      assign short_lvl     = diag_i.short_to_supply[gc] || diag_i.short_to_ground[gc];
      assign short_evt[gc] = short_lvl && !short_prev_ff[gc];
      assign pol_chg[gc]   = coil_i[gc].polarity != pol_prev_ff[gc];

      always_ff @(posedge mclk_i)
      begin
        if (!rstn_i)
        begin
          pol_prev_ff[gc]   <= 1'b0;
          short_prev_ff[gc] <= 1'b0;
        end
        else
        begin
          pol_prev_ff[gc]   <= coil_i[gc].polarity;
          short_prev_ff[gc] <= short_lvl;
        end
      end

      // RULE_12 interval without chopper event flags open load
      always_ff @(posedge mclk_i)
      begin
        if (!rstn_i)
          chop_seen_ff[gc] <= 1'b0;
        else if (pol_chg[gc])
          chop_seen_ff[gc] <= 1'b0;
        else if (coil_i[gc].chopper_event)
          chop_seen_ff[gc] <= 1'b1;
      end

      // RULE_13 set wins over the current based clear
      always_ff @(posedge mclk_i)
      begin
        if (!rstn_i)
          ol_ff[gc] <= 1'b0;
        else if (pol_chg[gc] && !chop_seen_ff[gc] && !coil_i[gc].chopper_event)
          ol_ff[gc] <= 1'b1;
        else if (coil_i[gc].current_above_16th)
          ol_ff[gc] <= 1'b0;
      end

      // RULE_15 count up per short; RULE_16 count down per polarity change
      always_ff @(posedge mclk_i)
      begin
        if (!rstn_i)
          cnt_ff[gc] <= 2'h0;
        else if (shut_ff[gc] && shut_clear)
          cnt_ff[gc] <= 2'h0;
        else if (shut_ff[gc])
          cnt_ff[gc] <= cnt_ff[gc];
        else if (short_evt[gc] && !pol_chg[gc] && cnt_ff[gc] != SHORT_LIMIT)
          cnt_ff[gc] <= cnt_ff[gc] + 2'h1;
        else if (pol_chg[gc] && !short_evt[gc] && cnt_ff[gc] != 2'h0)
          cnt_ff[gc] <= cnt_ff[gc] - 2'h1;
      end

      // RULE_17 latch off at the limit until released
      always_ff @(posedge mclk_i)
      begin
        if (!rstn_i)
          shut_ff[gc] <= 1'b0;
        else if (shut_ff[gc] && shut_clear)
          shut_ff[gc] <= 1'b0;
        else if (cnt_ff[gc] == SHORT_LIMIT)
          shut_ff[gc] <= 1'b1;
      end

      // RULE_15 current chopper cycle suspended on a short
      assign chopper_suspend_o[gc] = short_evt[gc];
    end
  endgenerate

  assign bridge_off_o = |shut_ff;

  // response build
  logic [9:0]        upper;
  logic [1:0]        rev_bits;
  logic [7:0]        lower;
  logic [RESP_W-1:0] resp_ff;

  // RULE_04 format follows the select in force
  always_comb
  begin
    case (readback_select_ff)
      // RULE_06 position, RULE_07 with polarity on top
      RD_POS:     upper = diag_i.sine_table_position;
      // RULE_08 load formats
      RD_LOAD:    upper = diag_i.load_measure_value;
      RD_LOAD_SC: upper = {diag_i.load_measure_value[9:5], diag_i.adaptive_current_scale};
      // RULE_09 diagnostic format
      RD_DIAG:    upper = {diag_i.supply_below_7v_flag, !driver_off,
                           diag_i.short_to_supply[1], diag_i.short_to_ground[1],
                           diag_i.short_to_supply[0], diag_i.short_to_ground[0],
                           diag_i.temp_detector};
      default:    upper = '0;
    endcase
  end

  // RULE_10 revision marker bits
  assign rev_bits = (NEWER_REV && readback_select_ff == RD_DIAG) ? 2'h3 : 2'h0;

  // RULE_15 short flags, RULE_19 warning, RULE_20 shutdown, RULE_21 stall
  assign lower = {standstill_ff, ol_ff[1], ol_ff[0], cnt_ff[1] != 2'h0,
                  cnt_ff[0] != 2'h0, diag_i.overtemp_warning_flag,
                  diag_i.overtemp_shutdown_flag, diag_i.stall_reached};

  // RULE_02 state frozen at frame start
  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
      resp_ff <= '0;
    else if (frame_start)
      resp_ff <= {upper, rev_bits, lower};
  end

  // RULE_21 stall test pin follows the stall flag
  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
      stall_test_output_o <= 1'b0;
    else
      stall_test_output_o <= diag_i.stall_reached;
  end

  // output released while deselected so the link can be shared
  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
      sdo_oen_o <= 1'b1;
    else
      sdo_oen_o <= sync_ff[PIN_CSN];
  end

  logic [RESP_W-1:0] load_word;
  assign load_word = {upper, rev_bits, lower};

  dsr_link_shifter u_shift (
    .mclk_i        (mclk_i),
    .rstn_i        (rstn_i),
    .frame_start_i (frame_start),
    .frame_end_i   (frame_end),
    .sclk_rise_i   (sclk_rise),
    .sclk_fall_i   (sclk_fall),
    .sdi_i         (sync_ff[PIN_SDI]),
    .load_i        (load_word),
    .sdo_o         (sdo_o),
    .rx_word_o     (rx_word),
    .rx_done_o     (rx_done)
  );

  assign readback_select_o  = readback_select_ff;
  assign chopper_off_time_o = chopper_off_time_ff;

  // checks
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rstn_i);

  a_readback_select_update: assert property ( // RULE_03
    rx_done && rx_addr == ADDR_CONF |=> readback_select_ff == $past(rx_word[READBACK_SELECT_LSB+:2]))
    else $error("readback select not captured");

  a_sdo_msb_first: assert property ( // RULE_02
    frame_start |=> sdo_o == resp_ff[RESP_W-1])
    else $error("first response bit is not the MSB");

  a_resp_format: assert property ( // RULE_04
    frame_start && readback_select_ff == RD_LOAD |=> resp_ff[19:10] == $past(diag_i.load_measure_value))
    else $error("load format wrong");

  a_rev_bits_mark: assert property ( // RULE_10
    frame_start |=> resp_ff[9:8] == ($past(readback_select_ff == RD_DIAG && NEWER_REV) ? 2'h3 : 2'h0))
    else $error("revision bits wrong");

  a_step_clears_still: assert property ( // RULE_11
    step_edge |=> !standstill_ff [*3])
    else $error("standstill flag not cleared by step");

  a_open_load_clear: assert property ( // RULE_13
    coil_i[0].current_above_16th && !pol_chg[0] |=> !ol_ff[0])
    else $error("open load flag not cleared");

  a_short_shutdown: assert property ( // RULE_17
    cnt_ff[0] == SHORT_LIMIT && !shut_ff[0] |=> bridge_off_o)
    else $error("bridge not switched off at limit");

  a_shut_held: assert property ( // RULE_18
    shut_ff[0] && !shut_clear |=> shut_ff[0] && bridge_off_o)
    else $error("shutdown released without clear");

  a_shut_release: assert property ( // RULE_18
    shut_ff[0] && shut_clear |=> !shut_ff[0])
    else $error("shutdown not released");

  a_short_suspend: assert property ( // RULE_15
    short_evt[1] && !pol_chg[1] && !(shut_ff[1] && shut_clear)
      |-> chopper_suspend_o[1] ##1 (lower[4] || shut_ff[1]))
    else $error("short not reported");

  a_stall_pin: assert property ( // RULE_21
    diag_i.stall_reached |=> stall_test_output_o)
    else $error("stall pin not driven");

  c_frame_done:  cover property (rx_done && rx_addr == ADDR_CONF);
  c_shutdown:    cover property ($rose(bridge_off_o));
  c_standstill:  cover property ($rose(standstill_ff));
  c_open_load:   cover property ($rose(ol_ff[0]));
endmodule // dsr_readback
`default_nettype wire

/* bench/dsr_ctrl_model.sv */
// Purpose: motion controller model, master of the serial control link
// Assumes: moves only on falling mclk_i edges, 200 ns link clock
// Notes: link clock idles low; data idles at inverse of last bit sent
`default_nettype none
module dsr_ctrl_model
  import dsr_pkg::*;
#(
  parameter int HALF = 4
)
(
  input  wire logic mclk_i,
  input  wire logic sdo_i,
  output logic      sclk_o,
  output logic      csn_o,
  output logic      sdi_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    sclk_o = 1'b0;
    csn_o  = 1'b1;
    sdi_o  = 1'b0;
  end

  // raw word handed back, no decision taken on any bit
  task automatic xfer(input logic [RESP_W-1:0] w, input int nb,
                      output logic [RESP_W-1:0] r);
    r = '0;
    @(negedge mclk_i);
    csn_o = 1'b0;
    repeat (HALF) @(negedge mclk_i);
    for (int i = 0; i < nb; i++)
    begin
      sdi_o = w[RESP_W-1-i];
      repeat (HALF) @(negedge mclk_i);
      sclk_o = 1'b1;
      repeat (HALF) @(negedge mclk_i);
      // sampled late in the bit, well clear of the slave's sync delay
      r[RESP_W-1-i] = sdo_i;
      sclk_o = 1'b0;
    end
    repeat (HALF) @(negedge mclk_i);
    csn_o = 1'b1;
    sdi_o = ~sdi_o;
    repeat (2*HALF) @(negedge mclk_i);
  endtask
endmodule // dsr_ctrl_model
`default_nettype wire

/* bench/dsr_readback_test.sv */
// Purpose: self-checking bench for the drive status readback block
// Assumes: standstill count cut to 64 clocks, newer revision
// Notes: each read rewrites the driver config word already in force
`default_nettype none
module dsr_readback_test
  import dsr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic              mclk, rstn, sclk, csn, sdi, sdo, oen, step, dis, boff, spin;
  dsr_diag_s         d;
  dsr_coil_s [1:0]   coil;
  logic [1:0]        sel_o, susp, cur_sel;
  logic [CHOPPER_OFF_TIME_W-1:0] chopper_off_time;
  logic              st, coil_a_open_load, sha, shb;
  logic [RESP_W-1:0] r;
  int                failures, n_tests;

  dsr_readback #(.STANDSTILL_CYCLES(64), .NEWER_REV(1'b1)) DUT (
    .mclk_i(mclk), .rstn_i(rstn), .sclk_i(sclk), .csn_i(csn), .sdi_i(sdi),
    .sdo_o(sdo), .sdo_oen_o(oen), .step_i(step), .driver_disable_input_i(dis),
    .diag_i(d), .coil_i(coil), .readback_select_o(sel_o),
    .chopper_off_time_o(chopper_off_time), .bridge_off_o(boff), .chopper_suspend_o(susp),
    .stall_test_output_o(spin));
  // released line shows the inverse, so a late output enable is caught
  dsr_ctrl_model u_ctrl (.mclk_i(mclk), .sdo_i(oen ? ~sdo : sdo), .sclk_o(sclk), .csn_o(csn),
    .sdi_o(sdi));

  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task automatic conclude;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [RESP_W-1:0] got, input logic [RESP_W-1:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask

  function automatic logic [RESP_W-1:0] cfg(input logic [1:0] s);
    return 20'hE0000 | (20'(s) << 4);
  endfunction

  function automatic logic [RESP_W-1:0] er(input logic [1:0] s);
    logic [9:0] u;
    case (s)
      2'h0: u = d.sine_table_position;
      2'h1: u = d.load_measure_value;
      2'h2: u = {d.load_measure_value[9:5], d.adaptive_current_scale};
      default: u = {d.supply_below_7v_flag, ~dis, d.short_to_supply[1],
                    d.short_to_ground[1], d.short_to_supply[0],
                    d.short_to_ground[0], d.temp_detector};
    endcase
    return {u, {2{s == 2'h3}}, st, 1'b0, coil_a_open_load, shb, sha, d.overtemp_warning_flag,
            d.overtemp_shutdown_flag, d.stall_reached};
  endfunction

  task automatic rd;
    u_ctrl.xfer(cfg(cur_sel), RESP_W, r);
    chk(r, er(cur_sel));
  endtask

  // optional chopper event, then a polarity change of coil c
  task automatic flip(input int c, input logic ev);
    coil[c].chopper_event = ev;
    cyc(1);
    coil[c].chopper_event = 1'b0;
    coil[c].polarity = ~coil[c].polarity;
    cyc(3);
  endtask

  task automatic short_a;
    d.short_to_ground[0] = 1'b1;
    #1;
    chk(20'(susp[0]), 20'h1);
    cyc(2);
    d.short_to_ground[0] = 1'b0;
    cyc(3);
  endtask

  task automatic t_bringup;
    logic [RESP_W-1:0] w [6];
    w = '{20'h901B4, 20'h94557, 20'hD001F, 20'hE0010, 20'h00000, 20'hA8202};
    // example words; only two addresses are taken here
    foreach (w[i])
      u_ctrl.xfer(w[i], RESP_W, r);
    chk(20'(sel_o), 20'h1);
    chk(20'(chopper_off_time), 20'h7);
    chk(20'(oen), 20'h1);
    $display("done bringup");
  endtask

  task automatic t_formats;
    d.sine_table_position = 10'h2A5;
    d.load_measure_value = 10'h1C3;
    d.adaptive_current_scale = 5'h0B;
    d.supply_below_7v_flag = 1'b1;
    d.temp_detector = 4'h5;
    d.overtemp_warning_flag = 1'b1;
    d.overtemp_shutdown_flag = 1'b1;
    d.short_to_supply = 2'h2;
    #1;
    chk(20'(susp), 20'h2);
    shb = 1'b1;
    for (int s = 0; s < 4; s++)
    begin
      cur_sel = 2'(s);
      u_ctrl.xfer(cfg(cur_sel), RESP_W, r);
      chk(20'(sel_o), 20'(cur_sel));
      rd();
    end
    d.short_to_supply = 2'h0;
    flip(1, 1'b1);
    shb = 1'b0;
    rd();
    $display("done formats");
  endtask

  task automatic t_short;
    short_a();
    short_a();
    flip(0, 1'b1);
    short_a();
    chk(20'(boff), 20'h0);
    short_a();
    chk(20'(boff), 20'h1);
    sha = 1'b1;
    rd();
    dis = 1'b1;
    cyc(6);
    chk(20'(boff), 20'h0);
    dis = 1'b0;
    sha = 1'b0;
    cyc(6);
    rd();
    repeat (3) short_a();
    chk(20'(boff), 20'h1);
    // zero off time must also release the latched shutdown
    u_ctrl.xfer(20'h80000, RESP_W, r);
    chk(20'(chopper_off_time), 20'h0);
    chk(20'(boff), 20'h0);
    $display("done short");
  endtask

  task automatic t_openload;
    flip(0, 1'b0);
    coil_a_open_load = 1'b1;
    rd();
    coil[0].current_above_16th = 1'b1;
    cyc(1);
    coil[0].current_above_16th = 1'b0;
    cyc(3);
    coil_a_open_load = 1'b0;
    rd();
    $display("done openload");
  endtask

  task automatic t_still;
    step = 1'b1;
    cyc(2);
    step = 1'b0;
    st = 1'b0;
    rd();
    cyc(80);
    st = 1'b1;
    rd();
    $display("done standstill");
  endtask

  task automatic t_stall_refuse;
    d.stall_reached = 1'b1;
    #1;
    chk(20'(spin), 20'h0);
    cyc(1);
    chk(20'(spin), 20'h1);
    rd();
    // short frame must leave the select untouched
    u_ctrl.xfer(cfg(2'h0), RESP_W-1, r);
    chk(20'(sel_o), 20'h3);
    rd();
    $display("done stall and refused frame");
  endtask

  initial
  begin
    repeat (30000) @(posedge mclk);
    failures++;
    $display("BAD %0t run did not finish", $time);
    conclude();
  end

  initial
  begin
    rstn = 1'b0;
    step = 1'b0;
    dis = 1'b0;
    d = '0;
    coil = '0;
    cur_sel = 2'h0;
    st = 1'b1;
    coil_a_open_load = 1'b0;
    sha = 1'b0;
    shb = 1'b0;
    failures = 0;
    n_tests = 0;
    cyc(20);
    rstn = 1'b1;
    cyc(4);
    t_bringup();
    t_formats();
    t_short();
    t_openload();
    t_still();
    t_stall_refuse();
    conclude();
  end
endmodule // dsr_readback_test
`default_nettype wire
